// ===== src/spw_pwm.sv
// Overview of operation
// - seven-bit blanking interval, eight nanoseconds per count
// - current-limit input blanked only while its blanking enable is set
// - edge-aligned counter counts upward from zero toward the period
// - high output asserted while count is at or below duty
// - high output deasserted once count passes duty
// - counter returns to zero past the period, starting a new cycle
// - complementary mode drives low output as inverse of high output
// - push-pull steers the pulse to high and low on alternate cycles
// - push-pull has no complement; both phases share one duty value
// - multi-phase adds the phase value to the time base
// - variable-phase mode may also drive the complementary low output
// - current-limit event cuts pulse; outputs take fault override data
// - override holds until the next cycle; period stays constant
// - current reset: fixed on-time, period never longer than programmed
// - discharge signal after the pulse restarts the counter
// - current reset mode may also drive the complementary low output
// - constant off-time is current reset using the complementary output
// - independent mode counts to the phase value then restarts
`default_nettype none
module spw_pwm
  import spw_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sense inputs
  input wire logic curlim_in,
  input wire logic fault_in,
  // power switch outputs
  output logic high_output,
  output logic low_output
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] duty;
    logic [CNT_W-1:0] phase;
    logic [BLANK_W-1:0] blank;
    logic [CNT_W-1:0] cnt;
    logic pp;
    logic ovr;
    logic hi;
    logic lo;
    logic [31:0] rdata;
    logic slverr;
  } spw_state_t;

  localparam spw_state_t ST_RST = '{
    ctrl: CTRL_RST, period: PERIOD_RST, duty: DUTY_RST, phase: PHASE_RST,
    blank: BLANK_RST, cnt: '0, pp: 1'b0, ovr: 1'b0, hi: 1'b0, lo: 1'b0,
    rdata: '0, slverr: 1'b0
  };

  spw_state_t q, d;
  spw_mode_t md;
  logic en;
  logic compl_en;
  logic hit;
  logic curlim_blk;
  logic fault_blk;
  logic blank_active;
  logic [CNT_W-1:0] wrap_lim;
  logic at_end;
  logic cur_rst;
  logic cyc_start;
  logic [CNT_W:0] sum;
  logic [CNT_W-1:0] cmp;
  logic pulse;
  logic trig;

  spw_blank u_blank (
    .pclk(pclk),
    .presetn(presetn),
    .blank_cfg(q.blank),
    .high_output(q.hi),
    .low_output(q.lo),
    .curlim_in(curlim_in),
    .fault_in(fault_in),
    .curlim_blk(curlim_blk),
    .fault_blk(fault_blk),
    .blank_active(blank_active)
  );

  always_comb begin
    d = q;
    md = spw_mode_t'(q.ctrl[CTRL_MODE_LSB +: CTRL_MODE_W]);
    en = q.ctrl[CTRL_EN_BIT];
    compl_en = q.ctrl[CTRL_COMPL_BIT];
    hit = (paddr == CTRL_ADDR) || (paddr == PERIOD_ADDR) || (paddr == DUTY_ADDR) ||
          (paddr == PHASE_ADDR) || (paddr == BLANK_ADDR) || (paddr == STATUS_ADDR);

    // read data is captured in the setup cycle so it leaves a flop
    if (psel && !penable) begin
      d.slverr = !hit;
      d.rdata = '0;
      case (paddr)
        CTRL_ADDR: d.rdata = 32'(q.ctrl);
        PERIOD_ADDR: d.rdata = 32'(q.period);
        DUTY_ADDR: d.rdata = 32'(q.duty);
        PHASE_ADDR: d.rdata = 32'(q.phase);
        BLANK_ADDR: d.rdata = 32'(q.blank);
        STATUS_ADDR: begin
          d.rdata[ST_HIGH_BIT] = q.hi;
          d.rdata[ST_LOW_BIT] = q.lo;
          d.rdata[ST_OVR_BIT] = q.ovr;
          d.rdata[ST_BLANK_BIT] = blank_active;
          d.rdata[ST_PP_BIT] = q.pp;
        end
        default: d.rdata = '0;
      endcase
    end

    // time base
    wrap_lim = (md == SPW_INDEP) ? q.phase : q.period;
    at_end = q.cnt >= wrap_lim;
    // discharge seen only after the pulse has ended
    cur_rst = (md == SPW_CURRST) && curlim_blk && (q.cnt > q.duty);
    cyc_start = en && (at_end || cur_rst);
    if (!en) begin
      d.cnt = '0;
    end else if (cyc_start) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + CNT_W'(1);
    end

    // phase is added modulo period plus one, the cycle length in counts, so the shifted wave keeps its rate
    sum = {1'b0, q.cnt} + {1'b0, q.phase};
    cmp = q.cnt;
    if (md == SPW_MULTIPH || md == SPW_VARPH) begin
      if (sum > {1'b0, q.period}) begin
        cmp = CNT_W'(sum - {1'b0, q.period} - 17'h00001);
      end else begin
        cmp = sum[CNT_W-1:0];
      end
    end
    pulse = cmp <= q.duty;

    if (!en) begin
      d.pp = 1'b0;
    end else if (cyc_start && md == SPW_PUSHPULL) begin
      d.pp = !q.pp;
    end

    // set wins over the cycle-start clear
    trig = en && (md == SPW_CURLIM) && (curlim_blk || fault_blk);
    if (!en) begin
      d.ovr = 1'b0;
    end else if (trig) begin
      d.ovr = 1'b1;
    end else if (cyc_start) begin
      d.ovr = 1'b0;
    end

    d.hi = 1'b0;
    d.lo = 1'b0;
    if (en) begin
      case (md)
        SPW_COMPL: begin
          d.hi = pulse;
          d.lo = !pulse;
        end
        SPW_PUSHPULL: begin
          d.hi = pulse && !q.pp;
          d.lo = pulse && q.pp;
        end
        SPW_VARPH: begin
          d.hi = pulse;
          d.lo = compl_en && !pulse;
        end
        SPW_CURRST: begin
          d.hi = pulse;
          d.lo = compl_en && !pulse;
        end
        SPW_CURLIM: begin
          if (trig || q.ovr) begin
            d.hi = q.ctrl[CTRL_FDAT_LSB];
            d.lo = q.ctrl[CTRL_FDAT_LSB + 1];
          end else begin
            d.hi = pulse;
          end
        end
        default: d.hi = pulse;
      endcase
    end

    // writes land in the access cycle; phase writes are taken at once,
    // glitch-free shifting is left to software timing
    if (psel && penable && pwrite && hit) begin
      case (paddr)
        CTRL_ADDR: d.ctrl = pwdata[CTRL_W-1:0];
        PERIOD_ADDR: d.period = pwdata[CNT_W-1:0];
        DUTY_ADDR: d.duty = pwdata[CNT_W-1:0];
        PHASE_ADDR: d.phase = pwdata[CNT_W-1:0];
        BLANK_ADDR: d.blank = pwdata[BLANK_W-1:0] & BLANK_WMASK;
        default: d.ctrl = q.ctrl;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pslverr = q.slverr;
  assign pready = 1'b1;
  assign high_output = q.hi;
  assign low_output = q.lo;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire en_md_edge = en && md == SPW_EDGE;

  edge_duty_cmp_a: assert property (en_md_edge && $stable(q.ctrl) |=>
    high_output == ($past(q.cnt) <= $past(q.duty)))
    else $error("high output does not follow count against duty");

  edge_past_duty_a: assert property (en_md_edge && q.cnt > q.duty && $stable(q.ctrl)
    |=> !high_output)
    else $error("high output stays on past duty");

  count_up_a: assert property (en && !cyc_start |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("time base failed to count up");

  period_wrap_a: assert property (en && md != SPW_INDEP && md != SPW_CURRST &&
    q.cnt >= q.period |=> q.cnt == 16'h0000)
    else $error("time base did not wrap past the period");

  compl_inverse_a: assert property (en && md == SPW_COMPL && $stable(q.ctrl) |=>
    low_output == !high_output)
    else $error("low output is not the inverse in complementary mode");

  pp_exclusive_a: assert property (en && md == SPW_PUSHPULL |=>
    !(high_output && low_output))
    else $error("both push-pull outputs on together");

  pp_alternate_a: assert property (en && md == SPW_PUSHPULL && cyc_start &&
    $stable(q.ctrl) |=> q.pp != $past(q.pp))
    else $error("push-pull phase did not alternate");

  ovr_force_a: assert property (trig && $stable(q.ctrl) |=>
    high_output == q.ctrl[CTRL_FDAT_LSB] && low_output == q.ctrl[CTRL_FDAT_LSB + 1])
    else $error("fault override data not on the outputs");

  ovr_hold_a: assert property (en && md == SPW_CURLIM && q.ovr && !cyc_start &&
    $stable(q.ctrl) |=> q.ovr)
    else $error("override dropped before the next cycle");

  currst_reset_a: assert property (en && md == SPW_CURRST && curlim_blk &&
    q.cnt > q.duty |=> q.cnt == 16'h0000)
    else $error("discharge signal did not restart the counter");

  currst_bound_a: assert property (en && md == SPW_CURRST && q.cnt >= q.period
    |=> q.cnt == 16'h0000)
    else $error("current reset period ran past the programmed period");

  indep_wrap_a: assert property (en && md == SPW_INDEP && q.cnt >= q.phase
    |=> q.cnt == 16'h0000)
    else $error("independent counter ignored its phase limit");

  curlim_mask_a: assert property (q.blank[CURLIM_BLANK_BIT] && blank_active
    |-> !curlim_blk)
    else $error("current limit passed during blanking");

  fault_pass_a: assert property (!q.blank[FAULT_BLANK_BIT] |-> fault_blk == fault_in)
    else $error("fault input blanked while blanking is off");

  blank_rise_a: assert property (q.blank[HIGH_RISE_BIT] &&
    q.blank[INTERVAL_LSB +: INTERVAL_W] != 7'h00 && $rose(high_output) |-> blank_active)
    else $error("enabled rising edge did not start blanking");

  unmapped_err_a: assert property (psel && !penable && !hit |=> pslverr)
    else $error("unmapped address not flagged");

  mapped_ok_a: assert property (psel && !penable && hit |=> !pslverr)
    else $error("mapped address flagged as an error");

  idle_off_a: assert property (!en |=> !high_output && !low_output)
    else $error("outputs driven while the channel is disabled");

  idle_count_a: assert property (!en |=> q.cnt == 16'h0000)
    else $error("time base runs while the channel is disabled");

  // a shifted channel wraps its compare early, so its pulse starts phase counts sooner
  mph_early_a: assert property (en && md == SPW_MULTIPH && q.phase != 16'h0000 &&
    q.phase <= q.period && q.cnt == q.period - q.phase + 16'h0001 && $stable(q.ctrl)
    |=> high_output)
    else $error("phase-shifted pulse did not start early");

  varph_compl_a: assert property (en && md == SPW_VARPH && compl_en &&
    $stable(q.ctrl) |=> low_output == !high_output)
    else $error("variable-phase low output is not the inverse");

  currst_compl_a: assert property (en && md == SPW_CURRST && compl_en &&
    $stable(q.ctrl) |=> low_output == !high_output)
    else $error("current reset low output is not the inverse");

  pp_low_pulse_a: assert property (en && md == SPW_PUSHPULL && q.pp &&
    q.cnt <= q.duty && $stable(q.ctrl) |=> low_output)
    else $error("push-pull low phase is shorter than the duty");

  ovr_clear_a: assert property (en && md == SPW_CURLIM && q.ovr && cyc_start &&
    !trig |=> !q.ovr)
    else $error("override outlived its cycle");

  blank_fall_a: assert property (q.blank[HIGH_FALL_BIT] &&
    q.blank[INTERVAL_LSB +: INTERVAL_W] != 7'h00 && $fell(high_output) |-> blank_active)
    else $error("enabled falling edge did not start blanking");

  blank_low_rise_a: assert property (q.blank[LOW_RISE_BIT] &&
    q.blank[INTERVAL_LSB +: INTERVAL_W] != 7'h00 && $rose(low_output) |-> blank_active)
    else $error("enabled low rising edge did not start blanking");

  curlim_pass_a: assert property (!q.blank[CURLIM_BLANK_BIT] |->
    curlim_blk == curlim_in)
    else $error("current limit blanked while blanking is off");

  fault_mask_a: assert property (q.blank[FAULT_BLANK_BIT] && blank_active
    |-> !fault_blk)
    else $error("fault passed during blanking");

  cov_pp_c: cover property (en && md == SPW_PUSHPULL && cyc_start ##[1:40] low_output);
  cov_ovr_c: cover property (trig ##1 q.ovr ##[1:200] cyc_start);
  cov_currst_c: cover property (en && md == SPW_CURRST && cur_rst);
  cov_blank_c: cover property (blank_active && curlim_in && !curlim_blk);
endmodule // spw_pwm
`default_nettype wire

// ===== shared/spw_pkg.sv
`default_nettype none
package spw_pkg;
  // apb register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] PERIOD_ADDR = 8'h04;
  localparam logic [7:0] DUTY_ADDR = 8'h08;
  localparam logic [7:0] PHASE_ADDR = 8'h0C;
  localparam logic [7:0] BLANK_ADDR = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h14;
  // control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_W = 3;
  localparam int CTRL_COMPL_BIT = 4;
  localparam int CTRL_FDAT_LSB = 5;
  // blanking_control fields
  localparam int BLANK_W = 16;
  localparam int HIGH_RISE_BIT = 15;
  localparam int HIGH_FALL_BIT = 14;
  localparam int LOW_RISE_BIT = 13;
  localparam int LOW_FALL_BIT = 12;
  localparam int FAULT_BLANK_BIT = 11;
  localparam int CURLIM_BLANK_BIT = 10;
  localparam int INTERVAL_LSB = 3;
  localparam int INTERVAL_W = 7;
  localparam logic [BLANK_W-1:0] BLANK_WMASK = 16'hFFF8;
  // status register fields
  localparam int ST_HIGH_BIT = 0;
  localparam int ST_LOW_BIT = 1;
  localparam int ST_OVR_BIT = 2;
  localparam int ST_BLANK_BIT = 3;
  localparam int ST_PP_BIT = 4;
  // widths and reset values
  localparam int CNT_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;
  localparam logic [CNT_W-1:0] PHASE_RST = 16'h0000;
  localparam logic [BLANK_W-1:0] BLANK_RST = 16'h0000;
  // timing
  localparam int BLANK_STEP_NS = 8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BLANK_CNT_W = 6;
  // operating modes, in control field order
  typedef enum logic [CTRL_MODE_W-1:0] {
    SPW_EDGE, SPW_COMPL, SPW_PUSHPULL, SPW_MULTIPH,
    SPW_VARPH, SPW_CURLIM, SPW_CURRST, SPW_INDEP
  } spw_mode_t;
endpackage
`default_nettype wire

// ===== src/spw_blank.sv
`default_nettype none
module spw_blank
  import spw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration and watched outputs
  input wire logic [BLANK_W-1:0] blank_cfg,
  input wire logic high_output,
  input wire logic low_output,
  // sense inputs and blanked results
  input wire logic curlim_in,
  input wire logic fault_in,
  output logic curlim_blk,
  output logic fault_blk,
  output logic blank_active
);
  typedef struct packed {
    logic prev_h;
    logic prev_l;
    logic [BLANK_CNT_W-1:0] cnt;
  } spw_blank_st_t;

  spw_blank_st_t q, d;
  logic start;
  logic [15:0] span_ns;
  logic [15:0] span_cyc;

  always_comb begin
    span_ns = 16'(blank_cfg[INTERVAL_LSB +: INTERVAL_W]) * 16'(BLANK_STEP_NS);
    // a least time, so round up to whole clocks
    span_cyc = (span_ns + 16'(CLK_PERIOD_NS - 1)) / 16'(CLK_PERIOD_NS);
    start = (blank_cfg[HIGH_RISE_BIT] && high_output && !q.prev_h) ||
            (blank_cfg[HIGH_FALL_BIT] && !high_output && q.prev_h) ||
            (blank_cfg[LOW_RISE_BIT] && low_output && !q.prev_l) ||
            (blank_cfg[LOW_FALL_BIT] && !low_output && q.prev_l);
    d = q;
    d.prev_h = high_output;
    d.prev_l = low_output;
    if (start) begin
      d.cnt = span_cyc[BLANK_CNT_W-1:0] - BLANK_CNT_W'(1);
      if (span_cyc == 16'h0000) begin
        d.cnt = '0;
      end
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - BLANK_CNT_W'(1);
    end
    // the edge cycle itself is covered too, so the first spike never leaks
    blank_active = (q.cnt != '0) || (start && span_cyc != 16'h0000);
    curlim_blk = curlim_in && !(blank_cfg[CURLIM_BLANK_BIT] && blank_active);
    fault_blk = fault_in && !(blank_cfg[FAULT_BLANK_BIT] && blank_active);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // spw_blank
`default_nettype wire

// ===== tb/spw_sw_model.sv
`default_nettype none
module spw_sw_model
  import spw_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // switch drive seen
  input wire logic high_output,
  // scenario commands
  input wire logic fault_cmd,
  input wire logic dis_cmd,
  // sense lines, idle low
  output logic curlim_in,
  output logic fault_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  logic [2:0] dly_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      dly_q <= 3'h0;
      fault_in <= 1'b0;
      curlim_in <= 1'b0;
    end else begin
      prev_q <= high_output;
      // short pulse only: a held fault would re-arm the override every cycle
      fault_in <= fault_cmd && high_output && !prev_q;
      // inductor discharged three cycles after the pulse ends
      if (dis_cmd && prev_q && !high_output) begin
        dly_q <= 3'h2;
      end else if (dly_q != 3'h0) begin
        dly_q <= dly_q - 3'h1;
      end
      curlim_in <= dis_cmd && (dly_q == 3'h1);
    end
  end
endmodule // spw_sw_model
`default_nettype wire

// ===== tb/spw_pwm_tb_top.sv
`default_nettype none
module spw_pwm_tb_top
  import spw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [32:0] v; int k;} spw_exp_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, curlim_in, fault_in, high_output, low_output;
  logic fault_cmd = 1'b0, dis_cmd = 1'b0, mdone = 1'b0;
  logic [32:0] m_cyc, m_hi, m_lo;
  spw_exp_t q[$];
  int err_total = 0, checks_done = 0, seed = 26298, d;
  always #12.5 pclk = ~pclk;
  spw_pwm DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .curlim_in(curlim_in), .fault_in(fault_in),
    .high_output(high_output), .low_output(low_output));
  spw_sw_model u_sw (.pclk(pclk), .presetn(presetn), .high_output(high_output),
    .fault_cmd(fault_cmd), .dis_cmd(dis_cmd), .curlim_in(curlim_in), .fault_in(fault_in));
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic note(string nm, logic [32:0] v, int k);
    spw_exp_t e;
    e.nm = nm;
    e.v = v;
    e.k = k;
    q.push_back(e);
  endtask
  task automatic chk(logic [32:0] seen);
    spw_exp_t e;
    bit ok;
    checks_done++;
    if (q.size() == 0) begin
      err_total++;
      $display("wrong value unexpected result expected none seen %0h", seen);
    end else begin
      e = q.pop_front();
      ok = (e.k == 0) ? (seen === e.v) : (e.k == 1) ? ((seen < e.v) === 1'b1)
        : ((seen > e.v) === 1'b1);
      if (!ok) begin
        err_total++;
        $display("wrong value %s expected %0h seen %0h", e.nm, e.v, seen);
      end
    end
  endtask
  // watcher: a read completes or a waveform measurement ends
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) chk({pslverr, prdata});
    if (mdone) begin
      chk(m_cyc);
      chk(m_hi);
      chk(m_lo);
    end
  end
  task automatic apb(logic w, logic [7:0] a, logic [31:0] dat, logic [32:0] ev);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    if (!w) note("register read", ev, 0);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // eight whole cycles, from one rise of the high output to the ninth
  task automatic meas();
    int r;
    logic ph;
    m_cyc = 0;
    m_hi = 0;
    m_lo = 0;
    r = 0;
    ph = 1'b1;
    // the enable cycle still shows idle outputs; a shifted pulse there is no true rise
    @(negedge pclk);
    repeat (600) begin
      @(negedge pclk);
      if (high_output === 1'b1 && ph !== 1'b1) r++;
      if (r == 9) break;
      if (r >= 1) begin
        m_cyc++;
        m_hi += (high_output === 1'b1);
        m_lo += (low_output === 1'b1);
      end
      ph = high_output;
    end
    @(posedge pclk) mdone <= 1'b1;
    @(posedge pclk) mdone <= 1'b0;
  endtask
  task automatic run(logic [2:0] md, logic cp, logic [1:0] fd, logic [15:0] per,
      logic [15:0] du, logic [15:0] ph, logic [15:0] bl, logic fl, logic ds,
      int ec, int kc, int eh, int kh, int el, int kl);
    apb(1'b1, CTRL_ADDR, 32'h0, 33'h0);
    apb(1'b1, PERIOD_ADDR, {16'h0, per}, 33'h0);
    apb(1'b1, DUTY_ADDR, {16'h0, du}, 33'h0);
    apb(1'b1, PHASE_ADDR, {16'h0, ph}, 33'h0);
    apb(1'b1, BLANK_ADDR, {16'h0, bl}, 33'h0);
    @(posedge pclk);
    fault_cmd <= fl;
    dis_cmd <= ds;
    apb(1'b1, CTRL_ADDR, {25'h0, fd, cp, md, 1'b1}, 33'h0);
    note("cycles", ec, kc);
    note("high count", eh, kh);
    note("low count", el, kl);
    meas();
    @(posedge pclk);
    fault_cmd <= 1'b0;
    dis_cmd <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    d = 4 + ({$random(seed)} % 4);
    for (int a = 0; a < 6; a++) apb(1'b0, 8'(a * 4), 32'h0, 33'h0);
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    apb(1'b1, BLANK_ADDR, 32'hFFFF, 33'h0);
    apb(1'b0, BLANK_ADDR, 32'h0, {17'h0, BLANK_WMASK});
    run(0, 0, 0, 9, d, 0, 0, 0, 0, 80, 0, 8 * (d + 1), 0, 0, 0);
    run(1, 0, 0, 9, d, 0, 0, 0, 0, 80, 0, 8 * (d + 1), 0, 80 - 8 * (d + 1), 0);
    run(2, 0, 0, 9, d, 0, 0, 0, 0, 160, 0, 8 * (d + 1), 0, 8 * (d + 1), 0);
    run(3, 0, 0, 9, d, 3, 0, 0, 0, 80, 0, 8 * (d + 1), 0, 0, 0);
    run(4, 1, 0, 9, d, 3, 0, 0, 0, 80, 0, 8 * (d + 1), 0, 80 - 8 * (d + 1), 0);
    run(7, 0, 0, 9, 2, 5, 0, 0, 0, 48, 0, 24, 0, 0, 0);
    run(5, 0, 2, 9, d, 0, 0, 1, 0, 80, 0, 8 * (d + 1), 1, 0, 2);
    run(5, 0, 2, 9, d, 0, 16'h2FF8, 1, 0, 80, 0, 8 * (d + 1), 1, 0, 2);
    run(5, 0, 2, 9, d, 0, 16'h8FF8, 1, 0, 80, 0, 8 * (d + 1), 0, 0, 0);
    run(5, 0, 2, 9, d, 0, 16'hC3F8, 1, 0, 80, 0, 8 * (d + 1), 1, 0, 2);
    // discharge comes five counts after the last on count: fixed on-time and off-time
    run(6, 1, 0, 15, d, 0, 0, 0, 1, 8 * (d + 6), 0, 8 * (d + 1), 0, 40, 0);
    run(6, 0, 0, 15, d, 0, 16'h8BF8, 0, 1, 8 * (d + 6), 0, 8 * (d + 1), 0, 0, 0);
    // blanked discharge never lands, so the period runs to its programmed end
    run(6, 0, 0, 15, d, 0, 16'h87F8, 0, 1, 128, 0, 8 * (d + 1), 0, 0, 0);
    repeat (4) @(posedge pclk);
    results();
  end
  // whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    results();
  end
endmodule // spw_pwm_tb_top
`default_nettype wire
